/* rtl/pcsa_core.sv */
// program counter, circular return stack and indirect data addressing with ahb-lite registers
// Summary of operation
// RULE_01 - program counter is 13 bits; low byte register is readable and writable.
// RULE_02 - upper five counter bits are not readable; loaded only via the high latch.
// RULE_03 - every reset clears the upper counter bits to zero.
// RULE_04 - writing the low byte copies high latch bits 4..0 into upper bits.
// RULE_05 - call and jump take 11 bits from instruction, top two from latch 4..3.
// RULE_06 - eight entry 13-bit return stack, pointer hidden from software.
// RULE_07 - call or interrupt vectoring pushes the full counter onto the stack.
// RULE_08 - return, return with literal and return from interrupt pop the counter.
// RULE_09 - pushes and pops leave the high latch unchanged.
// RULE_10 - stack wraps circularly; ninth push overwrites the first.
// RULE_11 - no overflow or underflow status is provided.
// RULE_12 - program space is 8K words split into 2K pages for call and jump.
// RULE_13 - parts with 4K words or less ignore high latch bit 4.
// RULE_14 - software should not use high latch bit 4 as storage.
// RULE_15 - table lookups adding to the low byte must watch 256-word boundaries.
// RULE_16 - indirect window has no storage; access goes to the file pointer address.
// RULE_17 - reading the window through itself returns 00h.
// RULE_18 - writing the window through itself changes no register.
// RULE_19 - indirect address is 9 bits: file pointer joined with the bank bit.
// RULE_20 - bank bit is the msb, file pointer supplies bits 7..0.
`timescale 1ns/1ps
`default_nettype none

module pcsa_core
  import pcsa_pkg::*;
#(
  parameter int PROG_WORDS = PROG_WORDS_FULL
) (
  input  wire logic                                 core_clk_in,
  input  wire logic                                 reset_n_in,
  // ahb-lite slave
  input  wire logic                                 hsel_in,
  input  wire logic [31:0]                          haddr_in,
  input  wire logic [1:0]                           htrans_in,
  input  wire logic                                 hwrite_in,
  input  wire logic [2:0]                           hsize_in,
  input  wire logic [pcsa_pkg::BUS_WIDTH-1:0]       hwdata_in,
  input  wire logic                                 hready_in,
  output logic      [pcsa_pkg::BUS_WIDTH-1:0]       hrdata_out,
  output logic                                      hreadyout_out,
  output logic                                      hresp_out,
  // sequencing requests from the instruction decoder, one-cycle pulses
  input  wire logic                                 step_in,
  input  wire logic                                 jump_in,
  input  wire logic                                 call_in,
  input  wire logic [pcsa_pkg::PAGE_ADDR_WIDTH-1:0] target_in,
  input  wire logic                                 return_in,
  input  wire logic                                 interrupt_in,
  output logic      [pcsa_pkg::PC_WIDTH-1:0]        instruction_pointer_out,
  // data space addressing
  input  wire logic [pcsa_pkg::FILE_ADDR_WIDTH-1:0] direct_addr_in,
  input  wire logic                                 data_read_in,
  input  wire logic                                 data_write_in,
  input  wire logic [pcsa_pkg::DATA_WIDTH-1:0]      mem_rdata_in,
  output logic      [pcsa_pkg::FILE_ADDR_WIDTH-1:0] eff_addr_out,
  output logic                                      eff_write_out,
  output logic                                      eff_read_out,
  output logic      [pcsa_pkg::DATA_WIDTH-1:0]      data_rdata_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam logic SMALL_PROG = (PROG_WORDS <= PROG_WORDS_SMALL);

  logic [PC_LOW_WIDTH-1:0]    pc_low_byte_reg;
  logic [PC_UPPER_WIDTH-1:0]  pc_upper_bits_reg;
  logic [PC_UPPER_WIDTH-1:0]  pc_high_latch_reg;
  logic [DATA_WIDTH-1:0]      file_pointer_reg;
  logic                       indirect_bank_bit_reg;
  logic [PC_WIDTH-1:0]        stack_mem_reg [STACK_DEPTH];
  logic [STACK_PTR_WIDTH-1:0] stack_ptr_reg;
  logic [STACK_PTR_WIDTH-1:0] stack_level_reg;
  logic [PC_WIDTH-1:0]        pc_now;
  logic [PC_WIDTH-1:0]        pc_next;
  logic [PC_WIDTH-1:0]        pc_plus_one;
  logic [PC_WIDTH-1:0]        push_value;
  logic [PC_WIDTH-1:0]        pop_value;
  logic [STACK_PTR_WIDTH-1:0] pop_index;
  logic [PC_UPPER_WIDTH-1:0]  latch_used;
  pcsa_action_type            action;

  // bus phase capture
  logic                       bus_wr_pend_reg;
  logic [REG_ADDR_WIDTH-1:0]  bus_addr_reg;
  logic                       bus_addr_ok;
  logic                       bus_rd_take;
  logic [BUS_WIDTH-1:0]       bus_rd_next;
  logic                       low_write;
  logic                       latch_write;
  logic                       fp_write;
  logic                       bank_write;
  logic                       fwd_hit;
  logic [BUS_WIDTH-1:0]       fwd_data;

  // indirect path
  logic                       window_hit;
  logic                       window_self;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, every response okay

  assign hreadyout_out = 1'b1;
  assign hresp_out     = HRESP_OKAY;

  // only whole aligned words are defined; others are taken and ignored
  assign bus_addr_ok = hsel_in && hready_in && htrans_in[1] &&
                       (hsize_in == HSIZE_WORD) && (haddr_in[1:0] == 2'b00);
  assign bus_rd_take = bus_addr_ok && !hwrite_in;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_wr_pend_reg <= 1'b0;
      bus_addr_reg    <= '0;
    end else if (hready_in) begin
      bus_wr_pend_reg <= bus_addr_ok && hwrite_in;
      bus_addr_reg    <= haddr_in[REG_ADDR_WIDTH-1:0];
    end
  end

  assign low_write   = bus_wr_pend_reg && (bus_addr_reg == PC_LOW_BYTE_OFS);
  assign latch_write = bus_wr_pend_reg && (bus_addr_reg == PC_HIGH_LATCH_OFS);
  assign fp_write    = bus_wr_pend_reg && (bus_addr_reg == FILE_POINTER_OFS);
  assign bank_write  = bus_wr_pend_reg && (bus_addr_reg == BANK_STATUS_OFS);

  // read data is prepared in the address phase so it leaves a flip-flop
  always_comb begin
    bus_rd_next = '0;
    case (haddr_in[REG_ADDR_WIDTH-1:0])
      PC_LOW_BYTE_OFS:   bus_rd_next[PC_LOW_WIDTH-1:0] = pc_low_byte_reg; // [RULE_01]
      PC_HIGH_LATCH_OFS: bus_rd_next[PC_UPPER_WIDTH-1:0] = pc_high_latch_reg;
      FILE_POINTER_OFS:  bus_rd_next[DATA_WIDTH-1:0] = file_pointer_reg;
      BANK_STATUS_OFS:   bus_rd_next[INDIRECT_BANK_POS] = indirect_bank_bit_reg;
      STACK_LEVEL_OFS:   bus_rd_next[STACK_PTR_WIDTH-1:0] = stack_level_reg;
      default:           bus_rd_next = '0;
    endcase
  end

  // a write lands only at the end of its data phase; a read taken in that
  // same cycle gets the new value from hwdata instead of the stale register
  always_comb begin
    fwd_hit  = 1'b0;
    fwd_data = '0;
    if (bus_wr_pend_reg && (bus_addr_reg == haddr_in[REG_ADDR_WIDTH-1:0])) begin
      case (bus_addr_reg)
        PC_LOW_BYTE_OFS: begin
          fwd_hit                    = 1'b1;
          fwd_data[PC_LOW_WIDTH-1:0] = hwdata_in[PC_LOW_WIDTH-1:0];
        end
        PC_HIGH_LATCH_OFS: begin
          fwd_hit                      = 1'b1;
          fwd_data[PC_UPPER_WIDTH-1:0] = hwdata_in[PC_UPPER_WIDTH-1:0];
        end
        FILE_POINTER_OFS: begin
          fwd_hit                  = 1'b1;
          fwd_data[DATA_WIDTH-1:0] = hwdata_in[DATA_WIDTH-1:0];
        end
        BANK_STATUS_OFS: begin
          fwd_hit                     = 1'b1;
          fwd_data[INDIRECT_BANK_POS] = hwdata_in[INDIRECT_BANK_POS];
        end
        default: begin
          fwd_hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata_out <= '0;
    end else if (bus_rd_take) begin
      hrdata_out <= fwd_hit ? fwd_data : bus_rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_high_latch_reg <= HIGH_LATCH_RESET;
    end else if (latch_write) begin
      // only software touches the latch; stack traffic never does [RULE_09]
      pc_high_latch_reg <= hwdata_in[PC_UPPER_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      file_pointer_reg <= FILE_PTR_RESET;
    end else if (fp_write) begin
      file_pointer_reg <= hwdata_in[DATA_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      indirect_bank_bit_reg <= BANK_BIT_RESET;
    end else if (bank_write) begin
      indirect_bank_bit_reg <= hwdata_in[INDIRECT_BANK_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter sequencing

  // small parts drop latch bit 4 so addresses stay inside 4K [RULE_13]
  assign latch_used = SMALL_PROG ?
                      {1'b0, pc_high_latch_reg[PC_UPPER_WIDTH-2:0]} : pc_high_latch_reg;

  assign pc_now      = {pc_upper_bits_reg, pc_low_byte_reg};
  assign pc_plus_one = PC_WIDTH'(pc_now + 1'b1);

  // a software low-byte write is a computed jump and outranks the decoder
  always_comb begin
    if (low_write) begin
      action = PCSA_ACT_LOW_WRITE;
    end else if (interrupt_in) begin
      action = PCSA_ACT_INTERRUPT;
    end else if (return_in) begin
      action = PCSA_ACT_RETURN;
    end else if (call_in) begin
      action = PCSA_ACT_CALL;
    end else if (jump_in) begin
      action = PCSA_ACT_JUMP;
    end else if (step_in) begin
      action = PCSA_ACT_STEP;
    end else begin
      action = PCSA_ACT_HOLD;
    end
  end

  assign pop_index = STACK_PTR_WIDTH'(stack_ptr_reg - 1'b1);
  assign pop_value = stack_mem_reg[pop_index];

  always_comb begin
    push_value = pc_now;
    pc_next    = pc_now;
    case (action)
      PCSA_ACT_LOW_WRITE: begin
        pc_next = {latch_used, hwdata_in[PC_LOW_WIDTH-1:0]}; // [RULE_04] [RULE_02]
      end
      PCSA_ACT_INTERRUPT: begin
        push_value = pc_now; // [RULE_07]
        pc_next    = INTERRUPT_VECTOR;
      end
      PCSA_ACT_RETURN: begin
        pc_next = pop_value; // [RULE_08]
      end
      PCSA_ACT_CALL: begin
        push_value = pc_plus_one; // [RULE_07]
        pc_next    = {latch_used[HIGH_LATCH_PAGE_HI:HIGH_LATCH_PAGE_LO], target_in}; // [RULE_05]
      end
      PCSA_ACT_JUMP: begin
        // 2K page from the latch, 11-bit offset from the instruction [RULE_12]
        pc_next = {latch_used[HIGH_LATCH_PAGE_HI:HIGH_LATCH_PAGE_LO], target_in}; // [RULE_05]
      end
      PCSA_ACT_STEP: begin
        pc_next = pc_plus_one;
      end
      default: begin
        pc_next = pc_now;
      end
    endcase
    if (SMALL_PROG) begin
      pc_next[PC_WIDTH-1] = 1'b0; // [RULE_13]
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_low_byte_reg   <= PC_RESET[PC_LOW_WIDTH-1:0];
      pc_upper_bits_reg <= PC_RESET[PC_WIDTH-1:PC_LOW_WIDTH]; // [RULE_03]
    end else begin
      pc_low_byte_reg   <= pc_next[PC_LOW_WIDTH-1:0]; // [RULE_01]
      pc_upper_bits_reg <= pc_next[PC_WIDTH-1:PC_LOW_WIDTH];
    end
  end

  assign instruction_pointer_out = pc_now;

  ////////////////////////////////////////////////////////////////////////////
  // return stack: the pointer simply wraps, so overflow silently overwrites
  // the oldest entry and underflow rereads stale ones; nothing flags either

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stack_ptr_reg <= STACK_PTR_RESET;
    end else if (action == PCSA_ACT_CALL || action == PCSA_ACT_INTERRUPT) begin
      stack_ptr_reg <= STACK_PTR_WIDTH'(stack_ptr_reg + 1'b1); // [RULE_10] [RULE_11]
    end else if (action == PCSA_ACT_RETURN) begin
      stack_ptr_reg <= pop_index; // [RULE_10]
    end
  end

  // storage is not reset, like the data memory it stands beside [RULE_06]
  always_ff @(posedge core_clk_in) begin
    if (action == PCSA_ACT_CALL || action == PCSA_ACT_INTERRUPT) begin
      stack_mem_reg[stack_ptr_reg] <= push_value; // [RULE_06]
    end
  end

  // count of live entries saturating at 7, so a full stack of 8 also reads 7; readable for diagnostics only;
  // the pointer itself stays hidden
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stack_level_reg <= STACK_PTR_RESET;
    end else if (action == PCSA_ACT_CALL || action == PCSA_ACT_INTERRUPT) begin
      if (stack_level_reg != STACK_PTR_WIDTH'(STACK_DEPTH - 1)) begin
        stack_level_reg <= STACK_PTR_WIDTH'(stack_level_reg + 1'b1);
      end
    end else if (action == PCSA_ACT_RETURN) begin
      if (stack_level_reg != '0) begin
        stack_level_reg <= STACK_PTR_WIDTH'(stack_level_reg - 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect data addressing

  // the window is any direct address whose low byte is the window location
  assign window_hit  = (direct_addr_in[DATA_WIDTH-1:0] == INDIRECT_WINDOW_FP); // [RULE_16]
  assign window_self = window_hit && (file_pointer_reg == INDIRECT_WINDOW_FP);

  always_comb begin
    if (window_hit) begin
      eff_addr_out = {indirect_bank_bit_reg, file_pointer_reg}; // [RULE_19] [RULE_20]
    end else begin
      eff_addr_out = direct_addr_in;
    end
  end

  // the window owns no storage, so a self-access must not reach memory
  assign eff_write_out = data_write_in && !window_self; // [RULE_18]
  assign eff_read_out  = data_read_in && !window_self;  // [RULE_16]

  always_comb begin
    if (window_self) begin
      data_rdata_out = SELF_READ_VALUE; // [RULE_17]
    end else begin
      data_rdata_out = mem_rdata_in;
    end
  end

endmodule

`default_nettype wire

/* rtl/pcsa_pkg.sv */
// constants for the program counter, return stack and indirect addressing block
package pcsa_pkg;

  // widths
  localparam int PC_WIDTH        = 13;
  localparam int PC_LOW_WIDTH    = 8;
  localparam int PC_UPPER_WIDTH  = 5;
  localparam int PAGE_ADDR_WIDTH = 11;
  localparam int STACK_DEPTH     = 8;
  localparam int STACK_PTR_WIDTH = 3;
  localparam int FILE_ADDR_WIDTH = 9;
  localparam int DATA_WIDTH      = 8;
  localparam int BUS_WIDTH       = 32;

  // program memory geometry
  localparam int PROG_WORDS_FULL  = 8192;
  localparam int PROG_WORDS_SMALL = 4096;
  localparam int PAGE_WORDS       = 2048;

  // register byte offsets on the bus
  localparam logic [7:0] PC_LOW_BYTE_OFS   = 8'h00;
  localparam logic [7:0] PC_HIGH_LATCH_OFS = 8'h04;
  localparam logic [7:0] FILE_POINTER_OFS  = 8'h08;
  localparam logic [7:0] BANK_STATUS_OFS   = 8'h0c;
  localparam logic [7:0] STACK_LEVEL_OFS   = 8'h10;
  localparam int         REG_ADDR_WIDTH    = 8;

  // field positions
  localparam int HIGH_LATCH_PAGE_HI = 4;
  localparam int HIGH_LATCH_PAGE_LO = 3;
  localparam int INDIRECT_BANK_POS  = 7;

  // reset values
  localparam logic [PC_WIDTH-1:0]       PC_RESET         = 13'h0000;
  localparam logic [PC_UPPER_WIDTH-1:0] HIGH_LATCH_RESET = 5'h00;
  localparam logic [DATA_WIDTH-1:0]     FILE_PTR_RESET   = 8'h00;
  localparam logic                      BANK_BIT_RESET   = 1'b0;
  localparam logic [STACK_PTR_WIDTH-1:0] STACK_PTR_RESET = 3'h0;

  // fixed addresses
  localparam logic [PC_WIDTH-1:0]        INTERRUPT_VECTOR   = 13'h0004;
  localparam logic [DATA_WIDTH-1:0]      INDIRECT_WINDOW_FP = 8'h00;
  localparam logic [DATA_WIDTH-1:0]      SELF_READ_VALUE    = 8'h00;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'b00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;

  // sequencing action chosen in one cycle, lowest priority first
  typedef enum logic [2:0] {
    PCSA_ACT_HOLD      = 3'b000,
    PCSA_ACT_STEP      = 3'b001,
    PCSA_ACT_JUMP      = 3'b011,
    PCSA_ACT_CALL      = 3'b010,
    PCSA_ACT_RETURN    = 3'b110,
    PCSA_ACT_INTERRUPT = 3'b111,
    PCSA_ACT_LOW_WRITE = 3'b101
  } pcsa_action_type;

endpackage

/* testbench/pcsa_core_props.sv */
// checker for the program counter, return stack and indirect addressing block
`timescale 1ns/1ps
`default_nettype none
module pcsa_core_props (
  input wire logic                                 core_clk_in,
  input wire logic                                 reset_n_in,
  input wire logic                                 hsel_in,
  input wire logic [31:0]                          haddr_in,
  input wire logic [1:0]                           htrans_in,
  input wire logic                                 hwrite_in,
  input wire logic                                 hready_in,
  input wire logic                                 step_in,
  input wire logic                                 jump_in,
  input wire logic                                 call_in,
  input wire logic [pcsa_pkg::PAGE_ADDR_WIDTH-1:0] target_in,
  input wire logic                                 return_in,
  input wire logic                                 interrupt_in,
  input wire logic [pcsa_pkg::PC_WIDTH-1:0]        instruction_pointer_out,
  input wire logic [pcsa_pkg::FILE_ADDR_WIDTH-1:0] direct_addr_in,
  input wire logic                                 data_write_in,
  input wire logic [pcsa_pkg::DATA_WIDTH-1:0]      mem_rdata_in,
  input wire logic [pcsa_pkg::FILE_ADDR_WIDTH-1:0] eff_addr_out,
  input wire logic                                 eff_write_out,
  input wire logic [pcsa_pkg::DATA_WIDTH-1:0]      data_rdata_out
);
  import pcsa_pkg::*;
  logic wr_low_reg;
  // a bus write to the low byte in its data phase outranks every core pulse
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      wr_low_reg <= 1'b0;
    else
      wr_low_reg <= hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in[7:0] == 8'h00;
  end
  wire self_win = direct_addr_in[7:0] == 8'h00 && eff_addr_out[7:0] == 8'h00;
  wire no_pri   = !interrupt_in && !return_in && !wr_low_reg;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////
  a_self_read_zero: assert property (self_win |-> data_rdata_out == 8'h00)
    else $error("self read not zero");
  a_self_write_nop: assert property (self_win |-> !eff_write_out)
    else $error("self write not blocked");
  a_direct_pass: assert property (direct_addr_in[7:0] != 8'h00 |->
    eff_addr_out == direct_addr_in && eff_write_out == data_write_in
    && data_rdata_out == mem_rdata_in) else $error("direct access altered");
  a_reset_clear: assert property ($rose(reset_n_in) |-> instruction_pointer_out == 13'h0000)
    else $error("pointer not cleared by reset");
  a_jump_page: assert property (jump_in && !call_in && no_pri |=>
    instruction_pointer_out[10:0] == $past(target_in)) else $error("jump offset wrong");
  a_irq_vector: assert property (interrupt_in && !wr_low_reg |=>
    instruction_pointer_out == INTERRUPT_VECTOR) else $error("vector not taken");
  a_call_return: assert property ((call_in && no_pri) ##1 (return_in && !interrupt_in
    && !wr_low_reg) |=> instruction_pointer_out == $past(instruction_pointer_out, 2) + 13'h1)
    else $error("return address wrong");
  a_step_incr: assert property (step_in && !jump_in && !call_in && no_pri |=>
    instruction_pointer_out == $past(instruction_pointer_out) + 13'h1) else $error("step wrong");
  c_call_ret: cover property (call_in ##1 return_in);
  c_self_wr: cover property (self_win && data_write_in);
  c_irq: cover property (interrupt_in);
endmodule
bind pcsa_core pcsa_core_props u_props (.core_clk_in, .reset_n_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hready_in, .step_in, .jump_in, .call_in, .target_in, .return_in,
  .interrupt_in, .instruction_pointer_out, .direct_addr_in, .data_write_in, .mem_rdata_in,
  .eff_addr_out, .eff_write_out, .data_rdata_out);
`default_nettype wire

/* testbench/pcsa_core_test.sv */
// self-checking bench for the program counter, return stack and indirect addressing
`timescale 1ns/1ps
`default_nettype none
module pcsa_core_test;
  import pcsa_pkg::*;
  localparam logic [4:0] STEP = 5'h01, JUMP = 5'h02, CALL = 5'h04, RET = 5'h08, IRQ = 5'h10;
  logic        clk = 1'b0;
  logic        rst_n, hsel, hwrite, drd, dwr;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [4:0]  op;
  logic [10:0] tgt;
  logic [8:0]  daddr, eaddr;
  logic [7:0]  mrd, drdata;
  logic [12:0] ip, ip_small;
  logic        erd, ewr, hresp;
  wire         hrdyo;
  int          checked, miscompares;
  pcsa_core #(.PROG_WORDS(PROG_WORDS_FULL)) u_dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(HSIZE_WORD), .hwdata_in(hwdata), .hready_in(hrdyo), .hrdata_out(hrdata),
    .hreadyout_out(hrdyo), .hresp_out(hresp), .step_in(op[0]), .jump_in(op[1]),
    .call_in(op[2]), .target_in(tgt), .return_in(op[3]), .interrupt_in(op[4]),
    .instruction_pointer_out(ip), .direct_addr_in(daddr), .data_read_in(drd),
    .data_write_in(dwr), .mem_rdata_in(mrd), .eff_addr_out(eaddr), .eff_write_out(ewr),
    .eff_read_out(erd), .data_rdata_out(drdata));
  // a copy sized for a 4K part: latch bit 4 must never reach its pointer
  pcsa_core #(.PROG_WORDS(PROG_WORDS_SMALL)) u_dut_small (.core_clk_in(clk),
    .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(HSIZE_WORD), .hwdata_in(hwdata), .hready_in(hrdyo),
    .hrdata_out(), .hreadyout_out(), .hresp_out(), .step_in(op[0]), .jump_in(op[1]),
    .call_in(op[2]), .target_in(tgt), .return_in(op[3]), .interrupt_in(op[4]),
    .instruction_pointer_out(ip_small), .direct_addr_in(daddr), .data_read_in(drd),
    .data_write_in(dwr), .mem_rdata_in(mrd), .eff_addr_out(), .eff_write_out(),
    .eff_read_out(), .data_rdata_out());
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ip(input logic [12:0] exp);
    #1;
    chk({19'h0, ip}, {19'h0, exp});
  endtask
  // bounded so a stuck ready ends the run instead of hanging it
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdyo !== 1'b1 && n < 20);
    if (hrdyo !== 1'b1) begin
      miscompares++;
      end_sim;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    wait_rdy;
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic act(input logic [4:0] o, input logic [10:0] t);
    @(posedge clk);
    op <= o;
    tgt <= t;
  endtask
  task automatic run(input logic [4:0] o, input logic [10:0] t, input logic [12:0] exp);
    act(o, t);
    act(5'h00, 11'h0);
    chk_ip(exp);
  endtask
  task automatic dat(input logic [8:0] a, input logic [7:0] m, input logic [18:0] exp);
    @(posedge clk);
    daddr <= a;
    mrd <= m;
    drd <= 1'b1;
    dwr <= 1'b1;
    #1;
    chk({13'h0, eaddr, erd, ewr, drdata}, {13'h0, exp});
  endtask
  task automatic rst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, hsel, hwrite, drd, dwr, haddr, hwdata, htrans, op, tgt, daddr, mrd} = '0;
    checked = 0;
    miscompares = 0;
    rst;
    chk_ip(13'h0000);
    for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h0);
    $display("reset values done");
    wr(PC_HIGH_LATCH_OFS, 32'hffff_ffff);
    rd_chk(PC_HIGH_LATCH_OFS, 32'h1f);
    wr(PC_LOW_BYTE_OFS, 32'h0000_01a5);
    chk_ip(13'h1fa5);
    chk({19'h0, ip_small}, 32'h0000_0fa5);
    rd_chk(PC_LOW_BYTE_OFS, 32'ha5);
    $display("low byte load done");
    run(JUMP, 11'h123, 13'h1923);
    chk({19'h0, ip_small}, 32'h0000_0923);
    run(STEP, 11'h0, 13'h1924);
    run(CALL, 11'h055, 13'h1855);
    run(RET, 11'h0, 13'h1925);
    act(CALL, 11'h7ff);
    run(RET, 11'h0, 13'h1926);
    run(IRQ, 11'h0, INTERRUPT_VECTOR);
    run(RET, 11'h0, 13'h1926);
    rd_chk(PC_HIGH_LATCH_OFS, 32'h1f);
    $display("paging and return done");
    // mid-run reset clears the latch as well as the pointer, which restarts at zero
    rst;
    chk_ip(13'h0000);
    for (int k = 0; k < 10; k++) run(CALL, 11'(k + 64), 13'(k + 64));
    rd_chk(STACK_LEVEL_OFS, 32'h7);
    for (int k = 9; k >= 1; k--) run(RET, 11'h0, k == 1 ? 13'h49 : 13'(k + 64));
    rd_chk(STACK_LEVEL_OFS, 32'h0);
    $display("stack wrap done");
    wr(FILE_POINTER_OFS, 32'h37);
    wr(BANK_STATUS_OFS, 32'h80);
    rd_chk(BANK_STATUS_OFS, 32'h80);
    dat(9'h100, 8'hc3, {9'h137, 2'b11, 8'hc3});
    dat(9'h125, 8'h5a, {9'h125, 2'b11, 8'h5a});
    wr(FILE_POINTER_OFS, 32'h0);
    wr(BANK_STATUS_OFS, 32'h0);
    dat(9'h000, 8'hc3, {9'h000, 2'b00, 8'h00});
    $display("indirect addressing done");
    end_sim;
  end
endmodule
`default_nettype wire
